//--- imp_core_model.sv
/*
 * Behavioural model of the processor core seen by the interrupt controller:
 * it drives the mask bits and the trace flag, and takes requests.
 * Assumes the bench sets the wanted mask state and take enable at edges.
 */
`timescale 1ns/1ps

module imp_core_model
    import imp_pkg::*;
(
    input wire logic core_clk,                  // System clock.
    input wire logic rst,                       // Async reset, high.
    input wire logic irq_req,                   // Request from controller.
    input wire logic [7:0] irq_vector,          // Presented vector number.
    input wire logic take_en,                   // Core accepts requests.
    input wire logic want_gmask,                // Wanted global mask bit.
    input wire logic want_umask,                // Wanted user mask bit.
    input wire logic [PRIO_W-1:0] want_mlevel,  // Wanted mask level.
    input wire logic want_trace,                // Wanted trace flag.
    output logic global_mask_bit,               // Global mask bit.
    output logic user_mask_bit,                 // User mask bit.
    output logic [PRIO_W-1:0] mask_level_field, // Mask level.
    output logic trace_pending,                 // Trace exception due.
    output logic [7:0] taken_vec                // Last vector fetched.
);
    logic took; // An interrupt is being handled.

    // ------------------------------------------------------------------
    // Acceptance and mask update
    // ------------------------------------------------------------------
    // global mask raised, vector fetched.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            took <= 1'b0;
            taken_vec <= 8'h00;
            global_mask_bit <= 1'b0;
            user_mask_bit <= 1'b0;
            mask_level_field <= 3'h0;
            trace_pending <= 1'b0;
        end else begin
            took <= take_en & (took | irq_req);
            // Fetch the vector only once per handled request.
            if (take_en && irq_req && !took) begin
                taken_vec <= irq_vector;
            end
            global_mask_bit <= want_gmask | (take_en & (took | irq_req));
            user_mask_bit <= want_umask;
            mask_level_field <= want_mlevel;
            trace_pending <= want_trace;
        end
    end
endmodule : imp_core_model

//--- imp_ctrl.sv
/*
 * Interrupt mask and priority controller: synchronises the pin requests,
 * masks every maskable source by the selected control mode, arbitrates and hands
 * the winning vector to the processor core in registered form.
 * Assumes the core supplies its mask bits on the same clock, takes the
 * request at its instruction boundary and holds requests until serviced.
 */
`timescale 1ns/1ps

module imp_ctrl
    import imp_pkg::*;
(
    input wire logic core_clk,                  // System clock.
    input wire logic rst,                       // Async reset, high.
    input wire logic [ADDR_W-1:0] reg_addr,     // Register byte address.
    input wire logic [DATA_W-1:0] reg_wdata,    // Register write data.
    input wire logic reg_we,                    // Write strobe.
    input wire logic reg_re,                    // Read strobe.
    output logic [DATA_W-1:0] reg_rdata,        // Read data, next cycle.
    input wire logic pin_nmi,                   // Non-maskable pin.
    input wire logic [PIN_CNT-1:0] pin_request_lines, // Maskable pins.
    input wire logic transfer_sw_done_event,    // Transfer done request.
    input wire logic watchdog_interval_event,   // Watchdog request.
    input wire logic refresh_match_event,       // Refresh match request.
    input wire logic converter_end_event,       // Converter end request.
    input wire logic [3:0] timer0_match_events, // Timer 0 matches A-D.
    input wire logic timer0_overflow_event,     // Timer 0 overflow.
    input wire logic global_mask_bit,           // Core global mask bit.
    input wire logic user_mask_bit,             // Core user mask bit.
    input wire logic [PRIO_W-1:0] mask_level_field, // Core mask level.
    input wire logic trace_pending,             // Core trace exception due.
    output logic irq_req,                       // Request to the core.
    output logic [7:0] irq_vector,              // Winning vector number.
    output logic [15:0] irq_vec_addr,           // Low vector address bits.
    output logic [PRIO_W-1:0] irq_level         // Winner's level for mask.
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    imp_mode_t mode_sel;                         // Selected control mode.
    logic addr_adv;                              // Advanced address mode.
    logic [NUM_GRP-1:0] level_select_reg;        // Per-group level bits.
    logic [NUM_GRP-1:0][PRIO_W-1:0] priority_field_reg; // Per-group levels.
    logic [PIN_CNT:0] pin_meta;                  // First sync stage.
    logic [PIN_CNT:0] pin_sync;                  // Second sync stage.
    logic [NUM_SRC-1:0] req;                     // All request levels.
    logic [NUM_SRC-1:0] cand;                    // Requests that pass masks.
    logic [NUM_SRC-1:0][KEY_W-1:0] key;          // Arbitration keys.
    logic use_lvl;                               // Mode uses level bits.
    logic use_prio;                              // Mode uses priority.
    logic found;                                 // Some request survives.
    logic [KEY_W-1:0] best_key;                  // Winning key.
    logic [IDX_W-1:0] best_idx;                  // Winning source index.
    logic win_lvl;                               // Winner's level bit.

    // Mask test for one maskable source in the current mode.
    function automatic logic imp_enable(
        input imp_mode_t mode,
        input logic lvl,
        input logic [PRIO_W-1:0] prio,
        input logic gmask,
        input logic umask,
        input logic [PRIO_W-1:0] mlevel
    );
        logic bit_ok;
        logic lvl_ok;
        // Level zero gated by global mask.
        // Level one blocked by both masks.
        bit_ok = lvl ? !(gmask && umask) : !gmask;
        lvl_ok = prio > mlevel;
        unique case (mode)
            IMP_MODE0: imp_enable = !gmask;
            IMP_MODE1: imp_enable = bit_ok;
            IMP_MODE2: imp_enable = lvl_ok;
            IMP_MODE3: imp_enable = bit_ok && lvl_ok;
        endcase
    endfunction : imp_enable

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------

    // Configuration register: mode field and address mode.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_sel <= IMP_MODE0;
            addr_adv <= 1'b0;
        end else if (reg_we && reg_addr == OFF_CFG) begin
            // Each of the four codes gives its own mode.
            mode_sel <= imp_mode_t'({reg_wdata[CFG_MODE_HI],
                                     reg_wdata[CFG_MODE_LO]});
            addr_adv <= reg_wdata[CFG_ADV];
        end
    end

    // Level select register, one bit per group.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level_select_reg <= RST_LVL;
        end else if (reg_we && reg_addr == OFF_LVL) begin
            level_select_reg <= reg_wdata[NUM_GRP-1:0];
        end
    end

    // Priority fields, split over two words of five groups each.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < NUM_GRP; k++) begin
                priority_field_reg[k] <= RST_PRIO;
            end
        end else if (reg_we && reg_addr == OFF_PRIO_LO) begin
            for (int k = 0; k < LO_GRPS; k++) begin
                priority_field_reg[k] <= reg_wdata[PRIO_W*k +: PRIO_W];
            end
        end else if (reg_we && reg_addr == OFF_PRIO_HI) begin
            for (int k = 0; k < LO_GRPS; k++) begin
                priority_field_reg[k+LO_GRPS] <=
                    reg_wdata[PRIO_W*k +: PRIO_W];
            end
        end
    end

    // Read data appear in the cycle after the strobe and only there.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= RD_ZERO;
        end else if (!reg_re) begin
            reg_rdata <= RD_ZERO;
        end else begin
            unique case (reg_addr)
                OFF_CFG: reg_rdata <= DATA_W'({addr_adv, mode_sel});
                OFF_LVL: reg_rdata <= DATA_W'(level_select_reg);
                OFF_PRIO_LO: reg_rdata <= DATA_W'(
                    priority_field_reg[LO_GRPS-1:0]);
                OFF_PRIO_HI: reg_rdata <= DATA_W'(
                    priority_field_reg[NUM_GRP-1:LO_GRPS]);
                OFF_STAT: reg_rdata <= DATA_W'(req);
                default: reg_rdata <= RD_ZERO;  // Unmapped reads zero.
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Request gathering
    // ------------------------------------------------------------------

    // Two-stage synchroniser for the asynchronous pins.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {pin_request_lines, pin_nmi};
            pin_sync <= pin_meta;
        end
    end

    // One request line per modelled source.
    // Internal events in ascending vector order.
    assign req = {timer0_overflow_event, timer0_match_events,
                  converter_end_event, refresh_match_event,
                  watchdog_interval_event, transfer_sw_done_event,
                  pin_sync};

    // Level bits outside mode two, fields in two and three.
    assign use_lvl = mode_sel != IMP_MODE2;
    assign use_prio = mode_sel == IMP_MODE2 || mode_sel == IMP_MODE3;

    // Per-source masking and key; shared groups read the same settings.
    for (genvar g = 0; g < NUM_SRC; g++) begin : src_g
        if (g == 0) begin : nmi_g
            // NMI bypasses every mask, top key.
            assign cand[g] = req[g];
            assign key[g] = {1'b1, 1'b0, NMI_LEVEL};
        end else begin : mask_g
            logic lvl;
            logic [PRIO_W-1:0] pr;
            assign lvl = level_select_reg[SRC_GRP[g]];
            assign pr = priority_field_reg[SRC_GRP[g]];
            assign cand[g] = req[g] && imp_enable(mode_sel, lvl, pr,
                global_mask_bit, user_mask_bit, mask_level_field);
            // Level bit ranks above the field.
            assign key[g] = {1'b0, use_lvl && lvl,
                             use_prio ? pr : {PRIO_W{1'b0}}};
        end
    end

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------

    // Ascending scan with a strict compare keeps the lowest index on ties.
    always_comb begin
        found = 1'b0;
        best_key = '0;
        best_idx = '0;
        for (int k = 0; k < NUM_SRC; k++) begin
            if (cand[k] && (!found || key[k] > best_key)) begin
                found = 1'b1;
                best_key = key[k];
                best_idx = IDX_W'(k);
            end
        end
    end

    // Registered hand-over to the core.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_req <= 1'b0;
            irq_vector <= 8'h00;
            irq_vec_addr <= 16'h0000;
            irq_level <= 3'h0;
            win_lvl <= 1'b0;
        end else begin
            // Held off while a trace exception is due.
            irq_req <= found && !trace_pending;
            irq_vector <= SRC_VEC[best_idx];
            // Two or four bytes per vector.
            irq_vec_addr <= addr_adv ? {6'h00, SRC_VEC[best_idx], 2'b00}
                                     : {7'h00, SRC_VEC[best_idx], 1'b0};
            irq_level <= best_key[PRIO_W-1:0];
            win_lvl <= best_key[PRIO_W];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence cfg_write_s;
        reg_we && reg_addr == OFF_CFG;
    endsequence

    sequence nmi_seen_s;
        pin_sync[0] && !trace_pending;
    endsequence

    mode_write_a: assert property (
        @(posedge core_clk) disable iff (rst)
        cfg_write_s |=> mode_sel == $past(reg_wdata[1:0]))
        else $error("Mode field did not follow the write.");

    nmi_wins_a: assert property (
        @(posedge core_clk) disable iff (rst)
        nmi_seen_s |=> irq_req && irq_vector == VEC_NMI)
        else $error("NMI was not presented.");

    mode0_block_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mode_sel == IMP_MODE0 && global_mask_bit && !pin_sync[0]
        |=> !irq_req)
        else $error("Mode 0 let a masked request through.");

    mode0_level_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mode_sel == IMP_MODE0 && !global_mask_bit && !pin_sync[0] &&
        !trace_pending && req[1] && level_select_reg[0]
        |=> irq_req && win_lvl)
        else $error("Level 1 source lost in mode 0.");

    lvl0_masked_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mode_sel == IMP_MODE1 && global_mask_bit && !pin_sync[0]
        |=> !irq_req || win_lvl)
        else $error("Level 0 request passed the global mask.");

    both_masks_a: assert property (
        @(posedge core_clk) disable iff (rst)
        mode_sel == IMP_MODE1 && global_mask_bit && user_mask_bit &&
        !pin_sync[0] |=> !irq_req)
        else $error("Request passed both mask bits.");

    above_mask_a: assert property (
        @(posedge core_clk) disable iff (rst)
        irq_req && irq_vector != VEC_NMI &&
        $past(mode_sel) == IMP_MODE2 |-> irq_level > $past(mask_level_field))
        else $error("Accepted level not above mask level.");

    vec_addr_a: assert property (
        @(posedge core_clk) disable iff (rst)
        irq_req |-> irq_vec_addr == ($past(addr_adv) ?
            {6'h00, irq_vector, 2'b00} : {7'h00, irq_vector, 1'b0}))
        else $error("Vector address scale wrong.");

    trace_first_a: assert property (
        @(posedge core_clk) disable iff (rst)
        trace_pending |=> !irq_req)
        else $error("Interrupt raised over a pending trace.");

endmodule : imp_ctrl

//--- imp_ctrl_tb.sv
/*
 * Self-checking bench for the interrupt controller: register tasks,
 * request sources and the core model, with expected vectors per mode.
 * Assumes the register map and latencies given in the controller package.
 */
`timescale 1ns/1ps

module imp_ctrl_tb;
    import imp_pkg::*;
    logic core_clk, rst, reg_we, reg_re, take_en, adv;
    logic want_g, want_u, want_tr;
    logic [2:0] want_ml;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [17:0] src; // One bit per modelled source, NMI first.
    logic gm, um, tp, irq_req;
    logic [2:0] ml, irq_level;
    logic [7:0] irq_vector, taken_vec;
    logic [15:0] irq_vec_addr;
    int errors, n_tests, cycles;
    // Vector numbers of the sources, in source index order.
    localparam int VECS[18] = '{7, 16, 17, 18, 19, 20, 21, 22, 23,
                                24, 25, 26, 28, 32, 33, 34, 35, 36};

    imp_ctrl DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .pin_nmi(src[0]),
        .pin_request_lines(src[8:1]), .transfer_sw_done_event(src[9]),
        .watchdog_interval_event(src[10]), .refresh_match_event(src[11]),
        .converter_end_event(src[12]), .timer0_match_events(src[16:13]),
        .timer0_overflow_event(src[17]), .global_mask_bit(gm),
        .user_mask_bit(um), .mask_level_field(ml), .trace_pending(tp),
        .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_vec_addr(irq_vec_addr), .irq_level(irq_level));

    imp_core_model core (.core_clk(core_clk), .rst(rst), .irq_req(irq_req),
        .irq_vector(irq_vector), .take_en(take_en), .want_gmask(want_g),
        .want_umask(want_u), .want_mlevel(want_ml), .want_trace(want_tr),
        .global_mask_bit(gm), .user_mask_bit(um), .mask_level_field(ml),
        .trace_pending(tp), .taken_vec(taken_vec));

    // ------------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------------
    // The clock toggles every half period of 10 ns.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Cuts a hang short well beyond the expected run length.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    // Compares one seen value with its expected value.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One write cycle on the register port.
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask : reg_wr

    // One read cycle; the data are checked in the cycle after the strobe.
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : reg_rd

    // Sets the core mask state and the pending sources together.
    task automatic drive(input logic g, u, input logic [2:0] m,
                         input logic [17:0] s);
        @(posedge core_clk);
        want_g <= g;
        want_u <= u;
        want_ml <= m;
        src <= s;
    endtask : drive

    // Lets the pin synchroniser settle, then checks the presented request.
    task automatic exp_irq(input logic req, input int vec);
        repeat (6) @(posedge core_clk);
        #1 chk(irq_req, req);
        if (req) begin
            chk(irq_vector, vec[7:0]);
            chk(irq_vec_addr, adv ? vec * 4 : vec * 2);
        end
    endtask : exp_irq

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, reg_we, reg_re, take_en, adv, want_g, want_u, want_tr} = 8'h80;
        {want_ml, reg_addr, reg_wdata, src} = '0;
        errors = 0;
        n_tests = 0;
        cycles = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values, then an unmapped address.
        reg_rd(OFF_CFG, 32'h0000_0000);
        reg_rd(OFF_PRIO_LO, 32'h0000_7fff);
        reg_rd(OFF_PRIO_HI, 32'h0000_7fff);
        reg_rd(OFF_LVL, 32'h0000_0000);
        reg_rd(8'h14, 32'h0000_0000);
        // each source alone, distinct vectors, both address modes.
        for (int a = 0; a < 2; a++) begin
            adv = a[0];
            reg_wr(OFF_CFG, {29'h0, a[0], 2'b00});
            for (int i = 0; i < 18; i++) begin
                drive(1'b0, 1'b0, 3'h0, 18'h1 << i);
                exp_irq(1'b1, VECS[i]);
                chk(irq_level, i == 0 ? 7 : 0);
                // global mask leaves only the non-maskable request.
                drive(1'b1, 1'b0, 3'h0, 18'h1 << i);
                exp_irq(i == 0, VECS[i]);
            end
        end
        adv = 1'b0;
        reg_wr(OFF_CFG, 32'h0000_0000);
        drive(1'b0, 1'b0, 3'h0, 18'h0_1000);
        reg_rd(OFF_STAT, 32'h0000_1000);
        // Ties go to the lowest vector; a level bit overrides that.
        drive(1'b0, 1'b0, 3'h0, 18'h0_1002);
        exp_irq(1'b1, 16);
        reg_wr(OFF_LVL, 32'h0000_0100);
        exp_irq(1'b1, 28);
        // Pin 3 shares the level bit of pin 2; timer events share one.
        reg_wr(OFF_LVL, 32'h0000_0004);
        drive(1'b0, 1'b0, 3'h0, 18'h0_0012);
        exp_irq(1'b1, 19);
        reg_wr(OFF_LVL, 32'h0000_0200);
        drive(1'b0, 1'b0, 3'h0, 18'h2_0002);
        exp_irq(1'b1, 36);
        // Mode 0: a level bit set on pin 0 beats the timer overflow.
        reg_wr(OFF_LVL, 32'h0000_0001);
        exp_irq(1'b1, 16);
        // Mode 1: level 1 survives a set global mask until user mask set.
        reg_wr(OFF_CFG, 32'h0000_0001);
        reg_wr(OFF_LVL, 32'h0000_0001);
        drive(1'b1, 1'b0, 3'h0, 18'h0_1002);
        exp_irq(1'b1, 16);
        drive(1'b1, 1'b0, 3'h0, 18'h0_1000);
        exp_irq(1'b0, 0);
        drive(1'b1, 1'b1, 3'h0, 18'h0_0002);
        exp_irq(1'b0, 0);
        drive(1'b0, 1'b1, 3'h0, 18'h0_1000);
        exp_irq(1'b1, 28);
        // Mode 2: priority fields against the mask level, level bits unused.
        reg_wr(OFF_CFG, 32'h0000_0002);
        reg_wr(OFF_PRIO_LO, 32'h0000_7ffb);
        reg_wr(OFF_PRIO_HI, 32'h0000_7bff);
        drive(1'b1, 1'b1, 3'h0, 18'h0_1002);
        exp_irq(1'b1, 28);
        chk(irq_level, 32'd5);
        drive(1'b1, 1'b1, 3'h4, 18'h0_1000);
        exp_irq(1'b1, 28);
        drive(1'b1, 1'b1, 3'h5, 18'h0_1000);
        exp_irq(1'b0, 0);
        // Mode 3: level bit first, then field and mask, then mask bits.
        reg_wr(OFF_CFG, 32'h0000_0003);
        drive(1'b0, 1'b0, 3'h0, 18'h0_1002);
        exp_irq(1'b1, 16);
        drive(1'b0, 1'b0, 3'h3, 18'h0_1002);
        exp_irq(1'b1, 28);
        chk(irq_level, 32'd5);
        drive(1'b1, 1'b1, 3'h0, 18'h0_1002);
        exp_irq(1'b0, 0);
        // A trace exception holds the request back.
        drive(1'b0, 1'b0, 3'h0, 18'h0_1000);
        @(posedge core_clk);
        want_tr <= 1'b1;
        exp_irq(1'b0, 0);
        @(posedge core_clk);
        want_tr <= 1'b0;
        exp_irq(1'b1, 28);
        // The core takes the request and masks further ones.
        @(posedge core_clk);
        take_en <= 1'b1;
        exp_irq(1'b0, 0);
        chk(taken_vec, 32'd28);
        complete_run();
    end
endmodule : imp_ctrl_tb

//--- imp_pkg.sv
/*
 * Shared constants for the interrupt mask and priority controller: the
 * register map, field positions, mode codes and the fixed source tables.
 * Assumes a 32-bit plain register port with 8-bit byte addresses.
 */
package imp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 18;    // Sources modelled here, NMI first.
    localparam int NUM_GRP = 10;    // Groups sharing level and priority.
    localparam int PIN_CNT = 8;     // Maskable request pins.
    localparam int ADDR_W = 8;      // Register address width.
    localparam int DATA_W = 32;     // Register data width.
    localparam int PRIO_W = 3;      // Width of a priority field.
    localparam int KEY_W = 5;       // NMI bit, level bit, priority field.
    localparam int IDX_W = 5;       // Width of a source index.
    localparam int LO_GRPS = 5;     // Groups held in the low priority word.

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CFG = 8'h00;     // Config register.
    localparam logic [ADDR_W-1:0] OFF_LVL = 8'h04;     // Level select.
    localparam logic [ADDR_W-1:0] OFF_PRIO_LO = 8'h08; // Groups 0 to 4.
    localparam logic [ADDR_W-1:0] OFF_PRIO_HI = 8'h0c; // Groups 5 to 9.
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;    // Pending requests.

    // Configuration register fields.
    localparam int CFG_MODE_LO = 0;   // Lower mode bit.
    localparam int CFG_MODE_HI = 1;   // Upper mode bit.
    localparam int CFG_ADV = 2;       // Advanced address mode.

    // Reset values.
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [NUM_GRP-1:0] RST_LVL = 10'h000;
    localparam logic [PRIO_W-1:0] RST_PRIO = 3'h7;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Control modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IMP_MODE0 = 2'b00,
        IMP_MODE1 = 2'b01,
        IMP_MODE2 = 2'b10,
        IMP_MODE3 = 2'b11
    } imp_mode_t;

    // ------------------------------------------------------------------
    // Source tables, index 0 is NMI, then ascending vector order
    // ------------------------------------------------------------------
    localparam logic [7:0] VEC_NMI = 8'h07;
    localparam logic [PRIO_W-1:0] NMI_LEVEL = 3'h7;
    localparam logic [NUM_SRC-1:0][7:0] SRC_VEC = {
        8'h24, 8'h23, 8'h22, 8'h21, 8'h20,   // Timer channel 0 events.
        8'h1c, 8'h1a, 8'h19, 8'h18,          // Converter, refresh, wdt, xfer.
        8'h17, 8'h16, 8'h15, 8'h14,          // Pins 7 to 4.
        8'h13, 8'h12, 8'h11, 8'h10,          // Pins 3 to 0.
        8'h07                                // Non-maskable request.
    };
    localparam logic [NUM_SRC-1:0][3:0] SRC_GRP = {
        4'h9, 4'h9, 4'h9, 4'h9, 4'h9,
        4'h8, 4'h7, 4'h6, 4'h5,
        4'h4, 4'h4, 4'h3, 4'h3,
        4'h2, 4'h2, 4'h1, 4'h0,
        4'h0
    };

endpackage : imp_pkg
